// file: tb_usart_timeout_guard_pdc_regs.sv
/*
 * tb top: bench around utg_core.
 * Assumes the package is compiled first.
 */
`timescale 1ns/100ps
module tb_usart_timeout_guard_pdc_regs;
    logic sys_clk, rst, rx_mem_ready, tx_fetch_ready, rx_char_accept;
    utg_pkg::utg_bus_req_t bus_req;
    utg_pkg::utg_mem_wr_t rx_mem_wr;
    logic [31:0] bus_rdata, tx_fetch_addr, d, base;
    logic [8:0] rx_char_data, tx_fetch_data, tx_char_data;
    logic bit_tick, rx_char_valid, transmit_holding_free, tx_char_load;
    logic tx_char_sent, tx_line_hold, rx_timeout, tx_fetch_valid;
    logic receive_transfer_done, transmit_transfer_done;
    logic [31:0] rxq[$], wa[$], wd[$], fa[$], fd[$], ld[$]; // model queues
    int mismatches = 0, total_checks = 0, tick_n = 0, hold_n = 0, i;
    logic [7:0] ra[7] = '{8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h44};
    logic [31:0] rm[7] = '{32'hFF, 32'hFF, '1, 32'hFFFF, '1, '0, '0};
    utg_core DUT (.*);
    utg_line_model LINE (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // random memory stalls; monitors fill queues
    always @(posedge sys_clk) begin
        rx_mem_ready <= 1'($urandom);
        tx_fetch_ready <= 1'($urandom);
        tx_fetch_data <= 9'($urandom);
        if (rx_char_valid && rx_char_accept) rxq.push_back(32'(rx_char_data));
        if (rx_mem_wr.valid && rx_mem_ready) wa.push_back(rx_mem_wr.addr);
        if (rx_mem_wr.valid && rx_mem_ready) wd.push_back(32'(rx_mem_wr.data));
        if (tx_fetch_valid && tx_fetch_ready) fa.push_back(tx_fetch_addr);
        if (tx_fetch_valid && tx_fetch_ready) fd.push_back(32'(tx_fetch_data));
        if (tx_char_load) ld.push_back(32'(tx_char_data));
        if (rx_char_valid) tick_n = 0;
        else if (bit_tick) tick_n++;
        if (bit_tick && tx_line_hold) hold_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic tx_run(input logic [31:0] g);
        int k;
        fa.delete();
        fd.delete();
        ld.delete();
        hold_n = 0;
        wr(8'h28, g);
        wr(8'h38, base);
        wr(8'h3C, 32'h3);
        for (k = 0; k < 2000 && ld.size() < 3; k++) @(negedge sys_clk);
        repeat (60) @(negedge sys_clk);
        chk(ld.size(), 3);
        chk(hold_n, 3 * g);
        chk(transmit_transfer_done, 1);
        for (k = 0; k < 3; k++) begin
            chk(fa[k], base + k);
            chk(ld[k], fd[k]);
        end
        $display("test transmit guard %0d done", g);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected run
    initial begin
        #5000000;
        mismatches++;
        close_out;
    end
    initial begin
        rst = 1'b1;
        bus_req = '0;
        void'($urandom(32'h4c4413ca));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            rd(ra[i], d);
            chk(d, 32'h0);
        end
        rd(8'h40, d);
        chk(d, 32'h6);
        // tx count keeps its low half zero so nothing is sent yet
        for (i = 0; i < 7; i++) begin
            base = $urandom & ((i == 5) ? 32'hFFFF0000 : '1);
            wr(ra[i], base);
            rd(ra[i], d);
            chk(d, base & rm[i]);
        end
        wr(8'h34, 32'h0);
        $display("test registers done");
        base = $urandom;
        wr(8'h30, base);
        LINE.send(17);
        @(negedge sys_clk);
        chk(rxq.size(), 16);
        chk(wa.size(), 0);
        wr(8'h34, 32'd17);
        for (i = 0; i < 400 && wa.size() < 16; i++) @(negedge sys_clk);
        LINE.send(1);
        LINE.send(1);
        repeat (20) @(negedge sys_clk);
        chk(wa.size(), 17);
        chk(receive_transfer_done, 1);
        for (i = 0; i < 17; i++) begin
            chk(wa[i], base + i);
            chk(wd[i], rxq[i]);
        end
        $display("test receive channel done");
        wr(8'h24, 32'h2);
        LINE.send(1);
        for (i = 0; i < 100 && tick_n < 5; i++) @(negedge sys_clk);
        LINE.send(1);
        for (i = 0; i < 400 && !rx_timeout; i++) @(negedge sys_clk);
        chk(tick_n, 8);
        rd(8'h40, d);
        chk(d & 32'h1, 32'h1);
        wr(8'h24, 32'h0);
        rd(8'h40, d);
        chk(d & 32'h1, 32'h0);
        LINE.send(1);
        repeat (200) @(negedge sys_clk);
        chk(rx_timeout, 0);
        $display("test time-out done");
        tx_run(0);
        tx_run(3);
        close_out;
    end
endmodule
bind utg_core utg_core_sva SVA (.*);

// file: utg_core.sv
/*
 * utg_core: idle time-out, time-guard,
 * two buffer channels and their
 * registers on a strobe port.
 * Assumes a bit_tick per bit period,
 * a receiver strobing characters,
 * a transmitter reporting sent,
 * and a memory with ready handshakes.
 */
// How it works
// [R1] idle-limit write also reloads and stops idle counter until next character
// [R2] idle limit zero disables time-out
// [R3] load limit on start and each character
// [R4] time-out span is limit times four bits
// [R5] guard zero lets characters go back-to-back
// [R6] line idle for guard bit periods after character
// [R7] software sets receive buffer base address
// [R8] receive count zero stops receive channel
// [R9] nonzero receive count moves ready characters
// [R10] software sets transmit buffer base address
// [R11] transmit count zero stops transmit channel
// [R12] nonzero transmit count feeds free holding register
// [R13] time-out flag set on expiry, never when disabled
// [R14] done flags mirror end-of-transfer of each channel
// [R15] each move advances pointer, decrements count
// [R16] idle counter steps every four bit periods
`timescale 1ns/100ps
module utg_core #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire utg_pkg::utg_bus_req_t bus_req,
    output logic [utg_pkg::UTG_DATA_W-1:0] bus_rdata,
    input wire logic bit_tick,
    input wire logic rx_char_valid,
    input wire logic [utg_pkg::UTG_CHAR_W-1:0] rx_char_data,
    output logic rx_char_accept,
    output utg_pkg::utg_mem_wr_t rx_mem_wr,
    input wire logic rx_mem_ready,
    output logic tx_fetch_valid,
    output logic [utg_pkg::UTG_DATA_W-1:0] tx_fetch_addr,
    input wire logic tx_fetch_ready,
    input wire logic [utg_pkg::UTG_CHAR_W-1:0] tx_fetch_data,
    input wire logic transmit_holding_free,
    output logic tx_char_load,
    output logic [utg_pkg::UTG_CHAR_W-1:0] tx_char_data,
    input wire logic tx_char_sent,
    output logic tx_line_hold,
    output logic rx_timeout,
    output logic receive_transfer_done,
    output logic transmit_transfer_done
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    generate
        if (FIFO_DEPTH < 2) begin : g_bad
            $error("utg_core: FIFO_DEPTH must be at least two");
        end
    endgenerate

    utg_pkg::utg_state_t st;       // registered state
    utg_pkg::utg_state_t next_st;  // next state
    logic receive_char_ready;      // a received character is waiting
    logic [utg_pkg::UTG_CHAR_W-1:0] fifo_char;  // oldest character
    logic rx_active;               // receive channel enabled
    logic rx_move;                 // character written to memory
    logic tx_move;                 // character fetched from memory
    logic wr_hit;                  // write strobe decode helper
    logic [utg_pkg::UTG_DATA_W-1:0] read_word;  // selected read value

    // ****************************************************************
    // receive buffering
    // ****************************************************************
    // characters wait here while memory is busy; when full the
    // receiver sees rx_char_accept low and must hold or drop
    utg_fifo #(
        .WIDTH(utg_pkg::UTG_CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(rx_char_valid),
        .in_data(rx_char_data),
        .in_ready(rx_char_accept),
        .out_valid(receive_char_ready),
        .out_data(fifo_char),
        .out_ready(rx_move)
    );

    // ****************************************************************
    // channel handshakes
    // ****************************************************************
    // [R8] zero count halts
    // [R9] move when ready
    assign rx_active = (st.regs.rx_count != utg_pkg::UTG_CNT_ZERO);
    assign rx_mem_wr.valid = rx_active && receive_char_ready;
    assign rx_mem_wr.addr = st.regs.rx_base;
    assign rx_mem_wr.data = fifo_char;
    assign rx_move = rx_mem_wr.valid && rx_mem_ready;

    // fetch stands only in its own state
    assign tx_fetch_valid = (st.tx_state == utg_pkg::UTG_TX_FETCH);
    assign tx_fetch_addr = st.regs.tx_base;
    assign tx_move = tx_fetch_valid && tx_fetch_ready;

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign bus_rdata = st.rdata;
    assign tx_char_load = st.tx_load;
    assign tx_char_data = st.tx_char;
    // [R6] guard holds line
    assign tx_line_hold = (st.tx_state == utg_pkg::UTG_TX_GUARD);
    assign rx_timeout = st.timeout;
    // [R14] done mirrors end
    assign receive_transfer_done = !rx_active;
    assign transmit_transfer_done =
        (st.regs.tx_count == utg_pkg::UTG_CNT_ZERO);

    // ****************************************************************
    // read selection
    // ****************************************************************
    // narrow fields sit low, upper bits and unmapped addresses read 0
    always_comb begin
        read_word = utg_pkg::UTG_RST_WORD;
        case (bus_req.addr)
            utg_pkg::UTG_OFF_IDLE_LIMIT: begin
                read_word[utg_pkg::UTG_LIMIT_W-1:0] = st.regs.idle_limit;
            end
            utg_pkg::UTG_OFF_GUARD: begin
                read_word[utg_pkg::UTG_LIMIT_W-1:0] = st.regs.guard;
            end
            utg_pkg::UTG_OFF_RX_PTR: begin
                read_word = st.regs.rx_base;
            end
            utg_pkg::UTG_OFF_RX_CNT: begin
                read_word[utg_pkg::UTG_CNT_W-1:0] = st.regs.rx_count;
            end
            utg_pkg::UTG_OFF_TX_PTR: begin
                read_word = st.regs.tx_base;
            end
            utg_pkg::UTG_OFF_TX_CNT: begin
                read_word[utg_pkg::UTG_CNT_W-1:0] = st.regs.tx_count;
            end
            utg_pkg::UTG_OFF_STATUS: begin
                read_word[utg_pkg::UTG_ST_TIMEOUT] = st.timeout;
                read_word[utg_pkg::UTG_ST_RX_DONE] = receive_transfer_done;
                read_word[utg_pkg::UTG_ST_TX_DONE] = transmit_transfer_done;
            end
            default: begin
                read_word = utg_pkg::UTG_RST_WORD;
            end
        endcase
    end

    assign wr_hit = bus_req.wr;

    // ****************************************************************
    // next state
    // ****************************************************************
    // order inside: channel moves first, software writes override
    // them, then the time-out flag sets last so an expiry beats a clear
    always_comb begin
        next_st = st;
        next_st.tx_load = 1'b0;
        // read data stand for exactly one cycle after the strobe
        next_st.rdata = bus_req.rd ? read_word : utg_pkg::UTG_RST_WORD;

        // [R15] advance, decrement
        if (rx_move) begin
            next_st.regs.rx_base = st.regs.rx_base + utg_pkg::UTG_PTR_STEP;
            next_st.regs.rx_count = st.regs.rx_count - utg_pkg::UTG_CNT_STEP;
        end

        // transmit sequencing
        case (st.tx_state)
            utg_pkg::UTG_TX_IDLE: begin
                // [R12] fetch when free
                // [R11] zero count halts
                if (st.regs.tx_count != utg_pkg::UTG_CNT_ZERO &&
                    transmit_holding_free) begin
                    next_st.tx_state = utg_pkg::UTG_TX_FETCH;
                end
            end
            utg_pkg::UTG_TX_FETCH: begin
                if (tx_move) begin
                    next_st.tx_char = tx_fetch_data;
                    next_st.tx_load = 1'b1;
                    // [R15] advance, decrement
                    next_st.regs.tx_base =
                        st.regs.tx_base + utg_pkg::UTG_PTR_STEP;
                    next_st.regs.tx_count =
                        st.regs.tx_count - utg_pkg::UTG_CNT_STEP;
                    // [R5] no guard, no wait
                    if (st.regs.guard == utg_pkg::UTG_LIMIT_ZERO) begin
                        next_st.tx_state = utg_pkg::UTG_TX_IDLE;
                    end else begin
                        next_st.tx_state = utg_pkg::UTG_TX_SEND;
                    end
                end
            end
            utg_pkg::UTG_TX_SEND: begin
                // [R6] start guard gap
                if (tx_char_sent) begin
                    next_st.guard_cnt = st.regs.guard;
                    next_st.tx_state = utg_pkg::UTG_TX_GUARD;
                end
            end
            utg_pkg::UTG_TX_GUARD: begin
                // [R6] count bit periods
                if (bit_tick) begin
                    next_st.guard_cnt =
                        st.guard_cnt - utg_pkg::UTG_LIMIT_ONE;
                    if (st.guard_cnt <= utg_pkg::UTG_LIMIT_ONE) begin
                        next_st.tx_state = utg_pkg::UTG_TX_IDLE;
                    end
                end
            end
            default: begin
                next_st.tx_state = utg_pkg::UTG_TX_IDLE;
            end
        endcase

        // [R3] reload on character
        if (rx_char_valid && (st.idle_armed || st.idle_running) &&
            st.regs.idle_limit != utg_pkg::UTG_LIMIT_ZERO) begin
            next_st.idle_cnt = st.regs.idle_limit;
            next_st.idle_pre = utg_pkg::UTG_IDLE_PRE_ZERO;
            next_st.idle_armed = 1'b0;
            next_st.idle_running = 1'b1;
        end else if (st.idle_running && bit_tick) begin
            // [R16] step every four
            if (st.idle_pre == utg_pkg::UTG_IDLE_PRE_LAST) begin
                next_st.idle_pre = utg_pkg::UTG_IDLE_PRE_ZERO;
                next_st.idle_cnt = st.idle_cnt - utg_pkg::UTG_LIMIT_ONE;
            end else begin
                next_st.idle_pre = st.idle_pre + 2'h1;
            end
        end

        // software writes win over channel updates
        if (wr_hit) begin
            case (bus_req.addr)
                utg_pkg::UTG_OFF_IDLE_LIMIT: begin
                    next_st.regs.idle_limit =
                        bus_req.wdata[utg_pkg::UTG_LIMIT_W-1:0];
                    // [R1] write reloads count, time-out starts on next character
                    next_st.idle_cnt = bus_req.wdata[utg_pkg::UTG_LIMIT_W-1:0];
                    next_st.idle_pre = utg_pkg::UTG_IDLE_PRE_ZERO;
                    next_st.idle_running = 1'b0;
                    next_st.timeout = 1'b0;
                    // [R2] zero disables
                    next_st.idle_armed =
                        (bus_req.wdata[utg_pkg::UTG_LIMIT_W-1:0] !=
                         utg_pkg::UTG_LIMIT_ZERO);
                end
                utg_pkg::UTG_OFF_GUARD: begin
                    next_st.regs.guard =
                        bus_req.wdata[utg_pkg::UTG_LIMIT_W-1:0];
                end
                utg_pkg::UTG_OFF_RX_PTR: begin
                    // [R7] software sets base
                    next_st.regs.rx_base = bus_req.wdata;
                end
                utg_pkg::UTG_OFF_RX_CNT: begin
                    next_st.regs.rx_count =
                        bus_req.wdata[utg_pkg::UTG_CNT_W-1:0];
                end
                utg_pkg::UTG_OFF_TX_PTR: begin
                    // [R10] software sets base
                    next_st.regs.tx_base = bus_req.wdata;
                end
                utg_pkg::UTG_OFF_TX_CNT: begin
                    next_st.regs.tx_count =
                        bus_req.wdata[utg_pkg::UTG_CNT_W-1:0];
                end
                default: begin
                    // unmapped or read-only: write ignored
                end
            endcase
        end

        // [R4] expiry after limit x4
        // [R13] flag on expiry
        if (st.idle_running && bit_tick &&
            st.idle_pre == utg_pkg::UTG_IDLE_PRE_LAST &&
            st.idle_cnt == utg_pkg::UTG_LIMIT_ONE &&
            st.regs.idle_limit != utg_pkg::UTG_LIMIT_ZERO &&
            !(rx_char_valid)) begin
            next_st.timeout = 1'b1;
            next_st.idle_running = 1'b0;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // everything resets to zero, matching the register reset values
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// file: utg_core_sva.sv
/*
 * utg_core_sva: port-level checks.
 * Assumes one clock and rst high active.
 */
`timescale 1ns/100ps
module utg_core_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire utg_pkg::utg_bus_req_t bus_req,
    input wire logic bit_tick,
    input wire utg_pkg::utg_mem_wr_t rx_mem_wr,
    input wire logic rx_mem_ready,
    input wire logic tx_fetch_valid,
    input wire logic [31:0] tx_fetch_addr,
    input wire logic tx_fetch_ready,
    input wire logic [8:0] tx_fetch_data,
    input wire logic tx_char_load,
    input wire logic [8:0] tx_char_data,
    input wire logic tx_line_hold,
    input wire logic rx_timeout,
    input wire logic receive_transfer_done,
    input wire logic transmit_transfer_done
);
    // ****************************************************************
    // one clock domain
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    rx_stop_a: assert property (
        receive_transfer_done |-> !rx_mem_wr.valid) else $error("rx move");
    tx_stop_a: assert property (
        transmit_transfer_done |-> !tx_fetch_valid) else $error("tx fetch");
    rx_done_a: assert property (
        bus_req.wr && bus_req.addr == 8'h34 && bus_req.wdata[15:0] == 16'h0
        |=> receive_transfer_done) else $error("rx done flag");
    tx_busy_a: assert property (
        bus_req.wr && bus_req.addr == 8'h3C && bus_req.wdata[15:0] != 16'h0
        |=> !transmit_transfer_done) else $error("tx done flag");
    guard_quiet_a: assert property (
        tx_line_hold |-> !tx_fetch_valid && !tx_char_load)
        else $error("fetch in guard");
    fetch_load_a: assert property (
        tx_fetch_valid && tx_fetch_ready |=> tx_char_load &&
        tx_char_data == $past(tx_fetch_data)) else $error("load");
    fetch_hold_a: assert property (
        tx_fetch_valid && !tx_fetch_ready && !bus_req.wr
        |=> tx_fetch_valid && $stable(tx_fetch_addr)) else $error("fetch");
    rx_step_a: assert property (
        rx_mem_wr.valid && rx_mem_ready && !bus_req.wr
        |=> rx_mem_wr.addr == $past(rx_mem_wr.addr) + 32'h1)
        else $error("rx pointer");
    expiry_tick_a: assert property (
        $rose(rx_timeout) |-> $past(bit_tick)) else $error("expiry");
    restart_clear_a: assert property (
        bus_req.wr && bus_req.addr == 8'h24 |=> !rx_timeout)
        else $error("restart");
endmodule

// file: utg_fifo.sv
/*
 * utg_fifo: FIFO, valid/ready on both sides.
 * Assumes one clock and a power-of-two depth.
 */
`timescale 1ns/100ps
module utg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    // wrap needs a power-of-two depth
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("utg_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    // storage plus pointers carrying one extra wrap bit
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } utg_fifo_state_t;

    utg_fifo_state_t st;       // registered state
    utg_fifo_state_t next_st;  // next state
    logic full;
    logic empty;

    // ****************************************************************
    // flags
    // ****************************************************************
    // full when pointers differ only in the wrap bit
    assign full = (st.wr[AW] != st.rd[AW]) &&
                  (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign empty = (st.wr == st.rd);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st.mem[st.rd[AW-1:0]];

    // ****************************************************************
    // next state
    // ****************************************************************
    // push and pop may happen in the same cycle
    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// file: utg_line_model.sv
/*
 * utg_line_model: remote side of the line plus bit tick: strobes
 * received characters and shifts loaded characters out.
 * Assumes the bench seeds the random source.
 */
`timescale 1ns/100ps
module utg_line_model #(
    parameter int BIT_CYC = 4,
    parameter int CHAR_BITS = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic bit_tick,
    output logic rx_char_valid,
    output logic [8:0] rx_char_data,
    output logic transmit_holding_free,
    input wire logic tx_char_load,
    output logic tx_char_sent
);
    int div; // bit period divider
    int left; // bits still to shift
    logic busy; // shifter occupied
    // a load pulse takes the holding register at once
    assign transmit_holding_free = !busy && !tx_char_load;
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = 9'h0;
    end
    // start after a tick: chars 1-3 share no tick, then every fourth char does
    task automatic send(input int n);
        @(posedge sys_clk iff bit_tick);
        repeat (n) begin
            rx_char_valid <= 1'b1;
            rx_char_data <= 9'($urandom);
            @(posedge sys_clk);
        end
        rx_char_valid <= 1'b0;
        rx_char_data <= ~rx_char_data; // stale data never looks valid
    endtask
    // tick and transmit shifter
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div <= 0;
            bit_tick <= 1'b0;
            busy <= 1'b0;
            left <= 0;
            tx_char_sent <= 1'b0;
        end else begin
            div <= (div == BIT_CYC - 1) ? 0 : div + 1;
            bit_tick <= (div == BIT_CYC - 1);
            tx_char_sent <= 1'b0;
            if (tx_char_load) begin
                busy <= 1'b1;
                left <= CHAR_BITS;
            end else if (busy && bit_tick) begin
                left <= left - 1;
                busy <= (left > 1);
                tx_char_sent <= (left == 1);
            end
        end
    end
endmodule

// file: utg_pkg.sv
/*
 * utg_pkg: constants, register map and carrier types.
 * Assumes one clock and an outside bit-period tick.
 */
package utg_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int UTG_ADDR_W = 8;   // register port address width
    localparam int UTG_DATA_W = 32;  // register port data width
    localparam int UTG_CNT_W = 16;   // transfer count field width
    localparam int UTG_LIMIT_W = 8;  // idle-limit and guard field width
    localparam int UTG_CHAR_W = 9;   // nine-bit characters

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_IDLE_LIMIT = 8'h24;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_GUARD = 8'h28;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_RX_PTR = 8'h30;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_RX_CNT = 8'h34;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_TX_PTR = 8'h38;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_TX_CNT = 8'h3C;
    localparam logic [UTG_ADDR_W-1:0] UTG_OFF_STATUS = 8'h40;

    // status word bit positions
    localparam int UTG_ST_TIMEOUT = 0;
    localparam int UTG_ST_RX_DONE = 1;
    localparam int UTG_ST_TX_DONE = 2;

    // ****************************************************************
    // values and counts
    // ****************************************************************
    localparam logic [UTG_DATA_W-1:0] UTG_RST_WORD = 32'h0;
    localparam logic [UTG_DATA_W-1:0] UTG_PTR_STEP = 32'h1;
    localparam logic [UTG_CNT_W-1:0] UTG_CNT_STEP = 16'h1;
    localparam logic [UTG_CNT_W-1:0] UTG_CNT_ZERO = 16'h0;
    localparam logic [UTG_LIMIT_W-1:0] UTG_LIMIT_ZERO = 8'h0;
    localparam logic [UTG_LIMIT_W-1:0] UTG_LIMIT_ONE = 8'h1;
    // idle counter steps once per four bit periods: prescaler 0..3
    localparam logic [1:0] UTG_IDLE_PRE_LAST = 2'h3;
    localparam logic [1:0] UTG_IDLE_PRE_ZERO = 2'h0;

    // ****************************************************************
    // types
    // ****************************************************************
    // transmit channel sequencing
    typedef enum logic [1:0] {
        UTG_TX_IDLE = 2'b00,   // waiting for count and free holding reg
        UTG_TX_FETCH = 2'b01,  // fetch request standing toward memory
        UTG_TX_SEND = 2'b10,   // character handed over, wait until sent
        UTG_TX_GUARD = 2'b11   // line held idle for the guard gap
    } utg_tx_state_t;

    // software-visible register contents
    typedef struct packed {
        logic [UTG_LIMIT_W-1:0] idle_limit;
        logic [UTG_LIMIT_W-1:0] guard;
        logic [UTG_DATA_W-1:0] rx_base;
        logic [UTG_CNT_W-1:0] rx_count;
        logic [UTG_DATA_W-1:0] tx_base;
        logic [UTG_CNT_W-1:0] tx_count;
    } utg_regs_t;

    // whole state of the main module
    typedef struct packed {
        utg_regs_t regs;
        logic [UTG_DATA_W-1:0] rdata;
        logic [UTG_LIMIT_W-1:0] idle_cnt;
        logic [1:0] idle_pre;
        logic idle_armed;
        logic idle_running;
        logic timeout;
        utg_tx_state_t tx_state;
        logic [UTG_LIMIT_W-1:0] guard_cnt;
        logic [UTG_CHAR_W-1:0] tx_char;
        logic tx_load;
    } utg_state_t;

    // register port request from software
    typedef struct packed {
        logic [UTG_ADDR_W-1:0] addr;
        logic [UTG_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } utg_bus_req_t;

    // write of one received character toward memory
    typedef struct packed {
        logic valid;
        logic [UTG_DATA_W-1:0] addr;
        logic [UTG_CHAR_W-1:0] data;
    } utg_mem_wr_t;

endpackage
